// file: common/ubf_link_if.sv
// Serial link between the framing end and the receiving host.
// The line idles high; the testbench may tap txd directly.
`timescale 1ns/1ns
`default_nettype none
interface ubf_link_if;
  logic txd;
  modport dev (output txd);
  modport host (input txd);
endinterface : ubf_link_if
`default_nettype wire

// file: common/ubf_pkg.sv
// Shared constants, types and checksum helpers for the packet framer.
// Assumes a single 100 MHz clock on both ends of the serial link.
package ubf_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_BPS = 57600;
  // Rounded down; the rate error stays far below one percent
  localparam int BIT_CLKS = CLK_HZ / BAUD_BPS;
  localparam logic [10:0] BIT_CNT = 11'(BIT_CLKS - 1);
  localparam logic [10:0] HALF_CNT = 11'(BIT_CLKS / 2 - 1);
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ---------------------------------------------------------------
  // Byte values and packet layout
  // ---------------------------------------------------------------
  localparam logic [7:0] SYNC_BYTE = 8'hAA;
  localparam logic [7:0] EXT_BYTE = 8'h55;
  localparam logic [7:0] TYPE_QUALITY = 8'h02;
  localparam logic [7:0] TYPE_HEART = 8'h03;
  localparam logic [7:0] TYPE_RAW = 8'h80;
  localparam logic [7:0] RAW_LEN = 8'h02;
  localparam logic [7:0] QUALITY_OFF = 8'h00;
  localparam logic [7:0] QUALITY_ON = 8'hC8;
  localparam int TYPE_MULTI_BIT = 7;
  localparam int HDR_BYTES = 3;
  localparam int PAY_BYTES = 8;
  localparam int PKT_BYTES = HDR_BYTES + PAY_BYTES + 1;
  localparam logic [3:0] PKT_LAST = 4'(PKT_BYTES - 1);
  localparam logic [7:0] PAY_LEN = 8'(PAY_BYTES);
  localparam int MEM_BYTES = 256;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [10:0] CNT_RST = 11'h000;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_START = 2'b01,
    SER_DATA = 2'b11,
    SER_STOP = 2'b10
  } ubf_ser_t;

  typedef enum logic [2:0] {
    PS_SYNC1 = 3'b000,
    PS_SYNC2 = 3'b001,
    PS_LEN = 3'b011,
    PS_PAY = 3'b010,
    PS_CHK = 3'b110,
    PS_ROW = 3'b111,
    PS_RLEN = 3'b101,
    PS_RDATA = 3'b100
  } ubf_parse_t;

  function automatic logic [7:0] ubf_csum_add(input logic [7:0] acc,
                                              input logic [7:0] b);
    ubf_csum_add = 8'(acc + b);
  endfunction : ubf_csum_add

  function automatic logic [7:0] ubf_csum_final(input logic [7:0] acc);
    ubf_csum_final = ~acc;
  endfunction : ubf_csum_final

endpackage : ubf_pkg

// file: core/ubf_dev_end.sv
// Framing end: captures a measurement set, builds a packet, sends it.
// Assumes i_send and the sample inputs come from the same clock domain.
//
// Overview of operation
// - 57600 baud, 8 data, 1 start, 1 stop
// - Packet is header, payload, then checksum
// - Header is AA, AA, payload byte count
// - Count equals payload bytes before checksum
// - Checksum is inverted low byte of sum
// - Receiver drops packets whose checksum mismatches
// - Receiver parses records only after checksum passes
// - Records packed back to back, all consumed
// - Leading 55 bytes set extension level
// - Type byte never 55 nor AA
// - Types 00..7F carry one value byte
// - Types 80..FF carry length, then values
// - Receiver skips unknown records, keeps alignment
// - Type 03 carries heart rate
// - Type 02 quality: 0 off, 200 on
// - Type 80 length 2, 16-bit sample
// - Receiver resyncs on two marker bytes
`timescale 1ns/1ns
`default_nettype none
module ubf_dev_end (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_send,
  input wire logic [7:0] i_heart_rate,
  input wire logic i_sensor_on,
  input wire logic [15:0] i_raw_sample,
  output logic o_busy,
  output logic o_done,
  ubf_link_if.dev link
);
  import ubf_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ubf_ser_t state_reg;
  ubf_ser_t state_next;
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [3:0] idx_reg;
  logic [3:0] idx_next;
  logic [7:0] shf_reg;
  logic [7:0] shf_next;
  logic txd_reg;
  logic txd_next;
  logic done_reg;
  logic done_next;
  logic [7:0] pkt_reg [0:PKT_BYTES-1];
  logic [7:0] pkt_next [0:PKT_BYTES-1];

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] sum;
    sum = BYTE_RST;
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    idx_next = idx_reg;
    shf_next = shf_reg;
    txd_next = txd_reg;
    done_next = 1'b0;
    pkt_next = pkt_reg;
    unique case (state_reg)
      SER_IDLE: begin
        txd_next = 1'b1;
        // A request while a packet is going out is ignored
        if (i_send) begin
          pkt_next[0] = SYNC_BYTE;
          pkt_next[1] = SYNC_BYTE;
          pkt_next[2] = PAY_LEN;
          pkt_next[HDR_BYTES] = TYPE_QUALITY;
          pkt_next[HDR_BYTES+1] = i_sensor_on ? QUALITY_ON : QUALITY_OFF;
          pkt_next[HDR_BYTES+2] = TYPE_HEART;
          pkt_next[HDR_BYTES+3] = i_heart_rate;
          pkt_next[HDR_BYTES+4] = TYPE_RAW;
          pkt_next[HDR_BYTES+5] = RAW_LEN;
          pkt_next[HDR_BYTES+6] = i_raw_sample[15:8];
          pkt_next[HDR_BYTES+7] = i_raw_sample[7:0];
          for (int i = HDR_BYTES; i < HDR_BYTES + PAY_BYTES; i++) begin
            sum = ubf_csum_add(sum, pkt_next[i]);
          end
          pkt_next[PKT_BYTES-1] = ubf_csum_final(sum);
          idx_next = 4'h0;
          shf_next = SYNC_BYTE;
          cnt_next = BIT_CNT;
          txd_next = 1'b0;
          state_next = SER_START;
        end
      end
      SER_START: begin
        if (cnt_reg == CNT_RST) begin
          txd_next = shf_reg[0];
          bit_next = 3'h0;
          cnt_next = BIT_CNT;
          state_next = SER_DATA;
        end else begin
          cnt_next = 11'(cnt_reg - 11'h001);
        end
      end
      SER_DATA: begin
        if (cnt_reg == CNT_RST) begin
          cnt_next = BIT_CNT;
          if (bit_reg == LAST_BIT) begin
            txd_next = 1'b1;
            state_next = SER_STOP;
          end else begin
            shf_next = {1'b0, shf_reg[7:1]};
            txd_next = shf_reg[1];
            bit_next = 3'(bit_reg + 3'h1);
          end
        end else begin
          cnt_next = 11'(cnt_reg - 11'h001);
        end
      end
      SER_STOP: begin
        if (cnt_reg == CNT_RST) begin
          if (idx_reg == PKT_LAST) begin
            done_next = 1'b1;
            state_next = SER_IDLE;
          end else begin
            idx_next = 4'(idx_reg + 4'h1);
            shf_next = pkt_reg[4'(idx_reg + 4'h1)];
            txd_next = 1'b0;
            cnt_next = BIT_CNT;
            state_next = SER_START;
          end
        end else begin
          cnt_next = 11'(cnt_reg - 11'h001);
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_reg <= SER_IDLE;
      cnt_reg <= CNT_RST;
      bit_reg <= 3'h0;
      idx_reg <= 4'h0;
      shf_reg <= BYTE_RST;
      txd_reg <= 1'b1;
      done_reg <= 1'b0;
      for (int i = 0; i < PKT_BYTES; i++) begin
        pkt_reg[i] <= BYTE_RST;
      end
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      idx_reg <= idx_next;
      shf_reg <= shf_next;
      txd_reg <= txd_next;
      done_reg <= done_next;
      pkt_reg <= pkt_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.txd = txd_reg;
  assign o_busy = (state_reg != SER_IDLE);
  assign o_done = done_reg;

endmodule : ubf_dev_end
`default_nettype wire

// file: core/ubf_host_end.sv
// Receiving end: deserialises the line, checks packets, splits records.
// Assumes the line is asynchronous; it is synchronised before use.
`timescale 1ns/1ns
`default_nettype none
module ubf_host_end (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  ubf_link_if.host link,
  output logic [7:0] o_heart_rate,
  output logic o_heart_valid,
  output logic [7:0] o_quality,
  output logic o_quality_valid,
  output logic [15:0] o_raw_sample,
  output logic o_raw_valid,
  output logic o_pkt_ok,
  output logic o_crc_err,
  output logic o_frame_err
);
  import ubf_pkg::*;

  // ---------------------------------------------------------------
  // Line synchroniser and character receiver
  // ---------------------------------------------------------------
  logic meta_reg;
  logic rxd_reg;
  ubf_ser_t rs_reg;
  ubf_ser_t rs_next;
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [7:0] shf_reg;
  logic [7:0] shf_next;
  logic bvld_reg;
  logic bvld_next;
  logic ferr_reg;
  logic ferr_next;

  always_comb begin
    rs_next = rs_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    shf_next = shf_reg;
    bvld_next = 1'b0;
    ferr_next = 1'b0;
    if (cnt_reg != CNT_RST) begin
      cnt_next = 11'(cnt_reg - 11'h001);
    end
    unique case (rs_reg)
      SER_IDLE: begin
        if (!rxd_reg) begin
          cnt_next = HALF_CNT;
          rs_next = SER_START;
        end
      end
      SER_START: begin
        if (cnt_reg == CNT_RST) begin
          // A start bit gone high by mid-bit is a glitch
          rs_next = rxd_reg ? SER_IDLE : SER_DATA;
          cnt_next = BIT_CNT;
          bit_next = 3'h0;
        end
      end
      SER_DATA: begin
        if (cnt_reg == CNT_RST) begin
          shf_next = {rxd_reg, shf_reg[7:1]};
          cnt_next = BIT_CNT;
          bit_next = 3'(bit_reg + 3'h1);
          if (bit_reg == LAST_BIT) begin
            rs_next = SER_STOP;
          end
        end
      end
      SER_STOP: begin
        if (cnt_reg == CNT_RST) begin
          // low stop bit is framing error
          bvld_next = rxd_reg;
          ferr_next = !rxd_reg;
          rs_next = SER_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      meta_reg <= 1'b1;
      rxd_reg <= 1'b1;
      rs_reg <= SER_IDLE;
      cnt_reg <= CNT_RST;
      bit_reg <= 3'h0;
      shf_reg <= BYTE_RST;
      bvld_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else begin
      meta_reg <= link.txd;
      rxd_reg <= meta_reg;
      rs_reg <= rs_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      shf_reg <= shf_next;
      bvld_reg <= bvld_next;
      ferr_reg <= ferr_next;
    end
  end

  // ---------------------------------------------------------------
  // Packet checker and record walker
  // ---------------------------------------------------------------
  // The walk takes at most a few hundred cycles, far less than one
  // character time, so no byte is lost while records are split.
  ubf_parse_t ps_reg;
  ubf_parse_t ps_next;
  logic [7:0] mem_reg [0:MEM_BYTES-1];
  logic [7:0] mem_next [0:MEM_BYTES-1];
  logic [7:0] plen_reg, plen_next, ptr_reg, ptr_next, sum_reg, sum_next;
  logic [7:0] lvl_reg, lvl_next, code_reg, code_next, rlen_reg, rlen_next;
  logic lenok_reg, lenok_next;
  logic [15:0] val_reg, val_next, raw_reg, raw_next;
  logic [7:0] hr_reg, hr_next, qual_reg, qual_next;
  logic hrv_reg, hrv_next, qv_reg, qv_next, rawv_reg, rawv_next;
  logic ok_reg, ok_next, crc_reg, crc_next;

  always_comb begin
    logic [7:0] b;
    logic [15:0] v;
    b = mem_reg[ptr_reg];
    v = {val_reg[7:0], b};
    ps_next = ps_reg;
    mem_next = mem_reg;
    plen_next = plen_reg;
    ptr_next = ptr_reg;
    sum_next = sum_reg;
    lvl_next = lvl_reg;
    code_next = code_reg;
    rlen_next = rlen_reg;
    lenok_next = lenok_reg;
    val_next = val_reg;
    raw_next = raw_reg;
    hr_next = hr_reg;
    qual_next = qual_reg;
    hrv_next = 1'b0;
    qv_next = 1'b0;
    rawv_next = 1'b0;
    ok_next = 1'b0;
    crc_next = 1'b0;
    unique case (ps_reg)
      PS_SYNC1: begin
        if (bvld_reg && shf_reg == SYNC_BYTE) ps_next = PS_SYNC2;
      end
      PS_SYNC2: begin
        if (bvld_reg) begin
          ps_next = (shf_reg == SYNC_BYTE) ? PS_LEN : PS_SYNC1;
        end
      end
      PS_LEN: begin
        if (bvld_reg) begin
          plen_next = shf_reg;
          sum_next = BYTE_RST;
          ptr_next = BYTE_RST;
          ps_next = (shf_reg == BYTE_RST) ? PS_CHK : PS_PAY;
        end
      end
      PS_PAY: begin
        if (bvld_reg) begin
          mem_next[ptr_reg] = shf_reg;
          sum_next = ubf_csum_add(sum_reg, shf_reg);
          ptr_next = 8'(ptr_reg + 8'h01);
          if (ptr_reg == 8'(plen_reg - 8'h01)) ps_next = PS_CHK;
        end
      end
      PS_CHK: begin
        if (bvld_reg) begin
          ptr_next = BYTE_RST;
          lvl_next = BYTE_RST;
          if (shf_reg == ubf_csum_final(sum_reg)) begin
            ok_next = 1'b1;
            ps_next = (plen_reg == BYTE_RST) ? PS_SYNC1 : PS_ROW;
          end else begin
            crc_next = 1'b1;
            ps_next = PS_SYNC1;
          end
        end
      end
      PS_ROW: begin
        if (ptr_reg == plen_reg) begin
          ps_next = PS_SYNC1;
        end else begin
          ptr_next = 8'(ptr_reg + 8'h01);
          if (b == EXT_BYTE) begin
            lvl_next = 8'(lvl_reg + 8'h01);
          end else begin
            code_next = b;
            if (b[TYPE_MULTI_BIT]) begin
              ps_next = PS_RLEN;
            end else begin
              rlen_next = 8'h01;
              lenok_next = 1'b0;
              ps_next = PS_RDATA;
            end
          end
        end
      end
      PS_RLEN: begin
        if (ptr_reg == plen_reg) begin
          ps_next = PS_SYNC1;
        end else begin
          ptr_next = 8'(ptr_reg + 8'h01);
          rlen_next = b;
          lenok_next = (b == RAW_LEN);
          if (b == BYTE_RST) begin
            lvl_next = BYTE_RST;
            ps_next = PS_ROW;
          end else begin
            ps_next = PS_RDATA;
          end
        end
      end
      PS_RDATA: begin
        if (ptr_reg == plen_reg) begin
          ps_next = PS_SYNC1;
        end else begin
          ptr_next = 8'(ptr_reg + 8'h01);
          val_next = v;
          rlen_next = 8'(rlen_reg - 8'h01);
          if (rlen_reg == 8'h01) begin
            if (lvl_reg == BYTE_RST) begin
              if (code_reg == TYPE_QUALITY) begin
                qual_next = b;
                qv_next = 1'b1;
              end
              if (code_reg == TYPE_HEART) begin
                hr_next = b;
                hrv_next = 1'b1;
              end
              if (code_reg == TYPE_RAW && lenok_reg) begin
                raw_next = v;
                rawv_next = 1'b1;
              end
            end
            lvl_next = BYTE_RST;
            ps_next = PS_ROW;
          end
        end
      end
      default: ps_next = PS_SYNC1;
    endcase
    if (ferr_reg) ps_next = PS_SYNC1;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ps_reg <= PS_SYNC1;
      for (int i = 0; i < MEM_BYTES; i++) mem_reg[i] <= BYTE_RST;
      plen_reg <= BYTE_RST;
      ptr_reg <= BYTE_RST;
      sum_reg <= BYTE_RST;
      lvl_reg <= BYTE_RST;
      code_reg <= BYTE_RST;
      rlen_reg <= BYTE_RST;
      lenok_reg <= 1'b0;
      val_reg <= WORD_RST;
      raw_reg <= WORD_RST;
      hr_reg <= BYTE_RST;
      qual_reg <= BYTE_RST;
      hrv_reg <= 1'b0;
      qv_reg <= 1'b0;
      rawv_reg <= 1'b0;
      ok_reg <= 1'b0;
      crc_reg <= 1'b0;
    end else begin
      ps_reg <= ps_next;
      mem_reg <= mem_next;
      plen_reg <= plen_next;
      ptr_reg <= ptr_next;
      sum_reg <= sum_next;
      lvl_reg <= lvl_next;
      code_reg <= code_next;
      rlen_reg <= rlen_next;
      lenok_reg <= lenok_next;
      val_reg <= val_next;
      raw_reg <= raw_next;
      hr_reg <= hr_next;
      qual_reg <= qual_next;
      hrv_reg <= hrv_next;
      qv_reg <= qv_next;
      rawv_reg <= rawv_next;
      ok_reg <= ok_next;
      crc_reg <= crc_next;
    end
  end

  assign o_heart_rate = hr_reg;
  assign o_heart_valid = hrv_reg;
  assign o_quality = qual_reg;
  assign o_quality_valid = qv_reg;
  assign o_raw_sample = raw_reg;
  assign o_raw_valid = rawv_reg;
  assign o_pkt_ok = ok_reg;
  assign o_crc_err = crc_reg;
  assign o_frame_err = ferr_reg;

endmodule : ubf_host_end
`default_nettype wire

// file: tb/uart_biosignal_packet_framer_tb.sv
// Bench for the framer: both ends back to back, plus a driven second link.
// Assumes the design files and the shared package are compiled first.
`timescale 1ns/1ns
`default_nettype none
module uart_biosignal_packet_framer_tb;
  import ubf_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_send = 1'b0;
  logic [7:0] i_heart_rate = 8'h00;
  logic i_sensor_on = 1'b0;
  logic [15:0] i_raw_sample = 16'h0000;
  logic o_busy, o_done, hv_a, qv_a, rv_a, ok_a, ce_a, fe_a;
  logic hv_b, ok_b, ce_b, fe_b;
  logic [7:0] hr_a, q_a, hr_b;
  logic [15:0] raw_a;
  logic [7:0] n_hv_a = 8'h00, n_rv_a = 8'h00, n_ok_a = 8'h00;
  logic [7:0] n_hv_b = 8'h00, n_ok_b = 8'h00, n_ce_b = 8'h00, n_fe_b = 8'h00;
  logic [7:0] wire_q[$];
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  // ----------------------------------------------------------------
  // Design, second receiver and checker
  // ----------------------------------------------------------------
  ubf_link_if link_a ();
  ubf_link_if link_b ();
  ubf_dev_end i_ubf_dev_end (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_send(i_send), .i_heart_rate(i_heart_rate), .i_sensor_on(i_sensor_on),
    .i_raw_sample(i_raw_sample), .o_busy(o_busy), .o_done(o_done),
    .link(link_a.dev));
  ubf_host_end i_ubf_host_end (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .link(link_a.host), .o_heart_rate(hr_a), .o_heart_valid(hv_a),
    .o_quality(q_a), .o_quality_valid(qv_a), .o_raw_sample(raw_a),
    .o_raw_valid(rv_a), .o_pkt_ok(ok_a), .o_crc_err(ce_a),
    .o_frame_err(fe_a));
  // Second receiver faces a bench driver that can break the framing
  ubf_host_end i_ubf_host_end_b (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .link(link_b.host), .o_heart_rate(hr_b),
    .o_heart_valid(hv_b), .o_quality(), .o_quality_valid(),
    .o_raw_sample(), .o_raw_valid(), .o_pkt_ok(ok_b), .o_crc_err(ce_b),
    .o_frame_err(fe_b));
  ubf_link_assertions i_ubf_link_assertions (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .txd(link_a.txd), .i_send(i_send),
    .o_busy(o_busy), .o_done(o_done), .o_heart_valid(hv_a),
    .o_quality_valid(qv_a), .o_raw_valid(rv_a), .o_pkt_ok(ok_a),
    .o_crc_err(ce_a), .o_frame_err(fe_a));

  always #5 i_ref_clk = ~i_ref_clk;

  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (!i_sys_rst) begin
      n_hv_a <= n_hv_a + 8'(hv_a);
      n_rv_a <= n_rv_a + 8'(rv_a);
      n_ok_a <= n_ok_a + 8'(ok_a);
      n_hv_b <= n_hv_b + 8'(hv_b);
      n_ok_b <= n_ok_b + 8'(ok_b);
      n_ce_b <= n_ce_b + 8'(ce_b);
      n_fe_b <= n_fe_b + 8'(fe_b);
    end
    if (cyc == 600000) begin
      n_errors++;
      print_verdict();
    end
  end

  // Samples the first link mid-bit, independent of the receiver
  initial begin : wire_mon
    logic [7:0] b;
    forever begin
      @(negedge link_a.txd);
      repeat (868) @(posedge i_ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (1736) @(posedge i_ref_clk);
        b[i] = link_a.txd;
      end
      repeat (1736) @(posedge i_ref_clk);
      cmp_byte({7'h00, link_a.txd}, 8'h01);
      wire_q.push_back(b);
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic ser_byte(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      link_b.txd <= f[i];
      repeat (BIT_CLKS) @(posedge i_ref_clk);
    end
  endtask : ser_byte

  task automatic send_pkt(input logic [7:0] pay[$], input logic bad);
    logic [7:0] s;
    s = 8'h00;
    ser_byte(8'hAA, 1'b1);
    ser_byte(8'hAA, 1'b1);
    ser_byte(8'(pay.size()), 1'b1);
    foreach (pay[i]) begin
      ser_byte(pay[i], 1'b1);
      s += pay[i];
    end
    ser_byte(~s ^ {7'h00, bad}, 1'b1);
  endtask : send_pkt

  task automatic wait_done;
    int k;
    k = 0;
    do begin
      @(posedge i_ref_clk);
      k++;
    end while (o_done !== 1'b1 && k < 220000);
    cmp_byte({7'h00, o_done}, 8'h01);
  endtask : wait_done

  task automatic check_wire(input logic [7:0] hr, input logic on,
                            input logic [15:0] raw);
    logic [7:0] e[$];
    logic [7:0] s;
    e = {8'h02, on ? 8'hC8 : 8'h00, 8'h03, hr, 8'h80, 8'h02,
         raw[15:8], raw[7:0]};
    s = 8'h00;
    foreach (e[i]) s += e[i];
    e = {8'hAA, 8'hAA, 8'h08, e, ~s};
    foreach (e[i]) cmp_byte(wire_q.pop_front(), e[i]);
  endtask : check_wire

  task automatic dev_side;
    i_send <= 1'b1;
    i_heart_rate <= 8'h48;
    i_sensor_on <= 1'b1;
    i_raw_sample <= 16'h8001;
    @(posedge i_ref_clk);
    // Send stays high: refused while busy, taken again at done
    i_heart_rate <= 8'hFE;
    i_sensor_on <= 1'b0;
    i_raw_sample <= 16'h7FFE;
    wait_done();
    i_send <= 1'b0;
    cmp_byte(q_a, QUALITY_ON);
    cmp_byte(hr_a, 8'h48);
    cmp_word(raw_a, 16'h8001);
    wait_done();
    cmp_byte(q_a, QUALITY_OFF);
    cmp_byte(hr_a, 8'hFE);
    cmp_word(raw_a, 16'h7FFE);
    cmp_byte(n_ok_a, 8'h02);
    cmp_byte(n_hv_a, 8'h02);
    cmp_byte(n_rv_a, 8'h02);
    cmp_byte(8'(wire_q.size()), 8'h18);
    check_wire(8'h48, 1'b1, 16'h8001);
    check_wire(8'hFE, 1'b0, 16'h7FFE);
  endtask : dev_side

  task automatic host_side;
    logic [7:0] q[$];
    repeat (2000) @(posedge i_ref_clk);
    ser_byte(8'hAA, 1'b1);
    ser_byte(8'h11, 1'b1);
    q = {8'h03, 8'h5A};
    send_pkt(q, 1'b1);
    // Skipped: level-1 record, unknown long record, empty long record
    q = {8'h55, 8'h03, 8'h77, 8'h81, 8'h03, 8'h01, 8'h02, 8'h03,
         8'h84, 8'h00, 8'h03, 8'h3C};
    send_pkt(q, 1'b0);
    // A low stop bit must drop the packet, so the valid tail that
    // follows it may not complete the packet
    q = {8'hAA, 8'hAA, 8'h02, 8'h03, 8'h11};
    foreach (q[i]) ser_byte(q[i], 1'(i != 4));
    link_b.txd <= 1'b1;
    repeat (2000) @(posedge i_ref_clk);
    ser_byte(8'h11, 1'b1);
    ser_byte(8'hEB, 1'b1);
    repeat (2000) @(posedge i_ref_clk);
    cmp_byte(n_ce_b, 8'h01);
    cmp_byte(n_ok_b, 8'h01);
    cmp_byte(n_hv_b, 8'h01);
    cmp_byte(hr_b, 8'h3C);
    cmp_byte(n_fe_b, 8'h01);
  endtask : host_side

  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    link_b.txd = 1'b1;
    repeat (12) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    fork
      dev_side();
      host_side();
    join
    print_verdict();
  end
endmodule : uart_biosignal_packet_framer_tb
`default_nettype wire

// file: tb/ubf_link_assertions.sv
// Concurrent checks on the first link and the user signals of both ends.
// Assumes one clock domain; instantiated by the bench beside the link.
`timescale 1ns/1ns
`default_nettype none
module ubf_link_assertions (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic txd,
  input wire logic i_send,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_heart_valid,
  input wire logic o_quality_valid,
  input wire logic o_raw_valid,
  input wire logic o_pkt_ok,
  input wire logic o_crc_err,
  input wire logic o_frame_err
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [17:0] busy_reg, busy_next;
  logic [10:0] run_reg, run_next;
  logic [8:0] ok_reg, ok_next;
  logic txd_reg, txd_next;

  always_comb begin
    busy_next = o_busy ? 18'(busy_reg + 18'h00001) : 18'h00000;
    run_next = (txd != txd_reg) ? 11'h000 :
               (&run_reg ? run_reg : 11'(run_reg + 11'h001));
    // Saturates so a stale pass never excuses a late record
    ok_next = o_pkt_ok ? 9'h000 :
              (ok_reg[8] ? ok_reg : 9'(ok_reg + 9'h001));
    txd_next = txd;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      busy_reg <= 18'h00000;
      run_reg <= 11'h000;
      ok_reg <= 9'h100;
      txd_reg <= 1'b1;
    end else begin
      busy_reg <= busy_next;
      run_reg <= run_next;
      ok_reg <= ok_next;
      txd_reg <= txd_next;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_idle_high: assert property (!o_busy |-> txd)
    else $error("line not high while idle");
  a_start_bit: assert property ((i_send && !o_busy) |=> (o_busy && !txd))
    else $error("no start bit after accepted send");
  a_start_hold: assert property ($fell(txd) |-> !txd [*8])
    else $error("low level shorter than a bit");
  a_bit_length: assert property ((txd != txd_reg && o_busy && $past(o_busy))
    |-> run_reg >= 11'h6C6)
    else $error("line level changed inside a bit");
  a_done_time: assert property (o_done |->
    (busy_reg >= 18'h32DBD && busy_reg <= 18'h32DC1))
    else $error("packet length in cycles wrong");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_done_ends: assert property (o_done |-> (!o_busy && $past(o_busy)))
    else $error("done without end of busy");
  a_link_clean: assert property (!(o_crc_err || o_frame_err))
    else $error("receiver flagged a framer packet");
  a_rec_late: assert property ((o_heart_valid || o_quality_valid ||
    o_raw_valid) |-> !ok_reg[8])
    else $error("record without checksum pass");
endmodule : ubf_link_assertions
`default_nettype wire
